// *** bench/enclave_exit_state_frame_writer_bench.sv ***
// bench for the exit state frame writer: register bus, exits, resume, interrupts
`timescale 1ns/1ps
`include "frame_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module enclave_exit_state_frame_writer_bench;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, sw = 1'b0;
   logic entry = 1'b0, resume = 1'b0, slow = 1'b0, ce = 1'b1;
   logic [7:0] adr = 8'h00, vec = 8'h00;
   logic [31:0] wdat = 32'h0, o_wb_dat, rd;
   logic o_wb_ack, mvalid, ready, rvalid, busy, irq;
   logic [15:0][63:0] gpr;
   logic [63:0] maddr, mdata, rsp, rbp, fend;
   logic [63:0] slot [0:22];
   logic [63:0] sp = 64'h00007ffc_0000a000, bp = 64'h00007ffc_0000b000;
   logic [63:0] flags = 64'h246, rip = 64'h401000, fs = 64'h7000, gs = 64'h8000;
   logic [7:0] tbl [15] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h10, 8'h11, 8'h13,
      8'h0d, 8'h0e, 8'h0d, 8'h0e, 8'h02, 8'hff, 8'h03};
   int errors = 0, checked = 0;
   always #2.5 i_clk = ~i_clk;
   enclave_exit_state_frame_writer enclave_exit_state_frame_writer_i (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
      .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
      .i_exit_req(req), .i_exc_vector(vec), .i_exc_is_sw(sw), .i_gpr(gpr),
      .i_flags(flags), .i_rip(rip), .i_fs_base(fs), .i_gs_base(gs),
      .i_entry(entry), .i_entry_sp(sp), .i_entry_bp(bp), .i_resume(resume),
      .o_mem_valid(mvalid), .o_mem_addr(maddr), .o_mem_data(mdata), .i_mem_ready(ready),
      .o_restore_valid(rvalid), .o_restore_sp(rsp), .o_restore_bp(rbp),
      .o_busy(busy), .o_irq(irq));
   frame_sink frame_sink_i (.i_clk(i_clk), .i_slow(slow), .i_valid(mvalid),
      .i_addr(maddr), .i_data(mdata), .o_ready(ready), .o_slot(slot), .o_end(fend));
   task automatic close_out();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      rd = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) errors++;
   endtask
   // one-cycle strobe: 0 exit request, 1 entry, 2 resume
   task automatic pulse(input int w);
      @(posedge i_clk);
      if (w == 0) req <= 1'b1;
      else if (w == 1) entry <= 1'b1;
      else resume <= 1'b1;
      @(posedge i_clk);
      req <= 1'b0;
      entry <= 1'b0;
      resume <= 1'b0;
   endtask
   function automatic logic [31:0] reason(input logic [7:0] v, input logic s, d);
      logic rep;
      rep = (v inside {0, 1, 3, 5, 6, 16, 17, 19}) || (d && v inside {13, 14});
      return rep ? {1'b1, 20'h0, (s ? 3'h6 : 3'h3), v} : 32'h0;
   endfunction
   task automatic do_exit(input int k);
      logic [31:0] e;
      int n;
      e = reason(tbl[k], k == 14, k inside {10, 11});
      n = 0;
      slow <= k[0];
      wb(1'b1, `REG_CTRL, {31'h0, k inside {10, 11}});
      vec <= tbl[k];
      sw <= (k == 14);
      pulse(0);
      do begin
         @(posedge i_clk);
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      if (n >= 200) errors++;
      `CHK("restore sp", sp, rsp)
      `CHK("restore bp", bp, rbp)
      `CHK("busy at restore", 1'b1, busy)
      repeat (2) @(posedge i_clk);
      `CHK("busy after", 1'b0, busy)
      `CHK("valid after", 1'b0, mvalid)
      for (int i = 0; i < 16; i++) `CHK("gpr", gpr[i], slot[i])
      `CHK("flags", flags, slot[16])
      `CHK("rip", rip, slot[17])
      `CHK("saved sp", sp, slot[18])
      `CHK("saved bp", bp, slot[19])
      `CHK("reason", {32'h0, e}, slot[20])
      `CHK("fs", fs, slot[21])
      `CHK("gs", gs, slot[22])
      `CHK("frame end", 64'h1_0000_0000 + 64'(k + 1) * 64'h1000, fend)
      `CHK("irq up", 1'b1, irq)
      wb(1'b0, `REG_IRQ_STATUS, 32'h0);
      `CHK("status", e[31] ? 32'h1 : 32'h3, rd)
      wb(1'b0, `REG_LAST_REASON, 32'h0);
      `CHK("last reason", e, rd)
      wb(1'b1, `REG_IRQ_STATUS, 32'h7);
      @(posedge i_clk);
      `CHK("irq down", 1'b0, irq)
   endtask
   initial begin
      for (int i = 0; i < 16; i++) gpr[i] = {8'(i), 56'h5a5a5a5a5a5a5a};
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'b1;
      wb(1'b0, `REG_FRAME_SIZE, 32'h0);
      `CHK("size", 32'h1000, rd)
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, `REG_BASE_HI, 32'h1);
      wb(1'b1, `REG_IRQ_MASK, 32'h7);
      pulse(1);
      for (int k = 0; k < 15; k++) do_exit(k);
      wb(1'b1, `REG_IRQ_MASK, 32'h0);
      // a resume while the clock enable is low must leave the index alone
      ce <= 1'b0;
      pulse(2);
      ce <= 1'b1;
      pulse(2);
      wb(1'b0, `REG_FRAME_INDEX, 32'h0);
      `CHK("index", 32'he, rd)
      `CHK("masked irq", 1'b0, irq)
      wb(1'b1, `REG_IRQ_MASK, 32'h4);
      repeat (2) @(posedge i_clk);
      `CHK("resume irq", 1'b1, irq)
      close_out();
   end
   initial begin
      #100000;
      errors++;
      close_out();
   end
endmodule

// *** bench/frame_sink.sv ***
// frame memory sink standing on the memory side of the frame write port
`timescale 1ns/1ps
module frame_sink (
   // clock and stall mode
   input wire logic i_clk,
   input wire logic i_slow,
   // write port from the writer
   input wire logic i_valid,
   input wire logic [63:0] i_addr,
   input wire logic [63:0] i_data,
   output logic o_ready,
   // captured frame
   output logic [63:0] o_slot [0:22],
   output logic [63:0] o_end
);
   logic [11:0] off;
   // 4k aligned base and 4k frames put the region start at page offset f50
   assign off = i_addr[11:0] - 12'hf50;
   // ready is registered, so the first valid cycle of a frame is never taken
   always_ff @(posedge i_clk) begin
      o_ready <= i_valid & (~i_slow | ~o_ready);
   end
   always_ff @(posedge i_clk) begin
      if (i_valid & o_ready) begin
         o_slot[off[7:3]] <= i_data;
         if (off == 12'h0b0) begin
            o_end <= i_addr;
         end
      end
   end
endmodule

// *** hw/enclave_exit_state_frame_writer.sv ***
// general-register save region writer for asynchronous exits
`timescale 1ns/1ps
`include "frame_defs.svh"
module enclave_exit_state_frame_writer (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // exit request from the core sequencer
   input wire logic i_exit_req,
   input wire logic [7:0] i_exc_vector,
   input wire logic i_exc_is_sw,
   input wire logic [`GPR_COUNT-1:0][63:0] i_gpr,
   input wire logic [63:0] i_flags,
   input wire logic [63:0] i_rip,
   input wire logic [63:0] i_fs_base,
   input wire logic [63:0] i_gs_base,
   // entry and resume
   input wire logic i_entry,
   input wire logic [63:0] i_entry_sp,
   input wire logic [63:0] i_entry_bp,
   input wire logic i_resume,
   // frame memory write port
   output logic o_mem_valid,
   output logic [63:0] o_mem_addr,
   output logic [63:0] o_mem_data,
   input wire logic i_mem_ready,
   // pointer restore to the core
   output logic o_restore_valid,
   output logic [63:0] o_restore_sp,
   output logic [63:0] o_restore_bp,
   // status
   output logic o_busy,
   output logic o_irq
);
   frame_pkg::wr_state_e state;
   frame_pkg::wr_state_e next_state;
   logic detail_sel;
   logic [63:0] frame_base;
   logic [31:0] frame_size;
   logic [31:0] frame_index;
   logic [31:0] last_reason;
   logic [`IRQ_WIDTH-1:0] irq_status;
   logic [`IRQ_WIDTH-1:0] irq_mask;
   logic [`IRQ_WIDTH-1:0] next_status;
   logic [`IRQ_WIDTH-1:0] irq_set;
   logic [`IRQ_WIDTH-1:0] irq_clr;
   frame_pkg::qword_t outside_stack_pointer;
   frame_pkg::qword_t outside_frame_pointer;
   frame_pkg::qword_t gpr_lat [`GPR_COUNT];
   frame_pkg::qword_t flags_lat;
   frame_pkg::qword_t rip_lat;
   frame_pkg::qword_t fs_segment_base;
   frame_pkg::qword_t gs_segment_base;
   frame_pkg::qword_t region_base;
   frame_pkg::qword_t next_frame_end;
   logic [31:0] reason_lat;
   logic reported_lat;
   logic [4:0] slot;
   logic [4:0] next_slot;
   logic accept;
   logic take;
   logic last_take;
   logic resume_ok;
   logic wb_req;
   logic wb_wr;
   logic [31:0] rd_word;

   exit_reason_if rsn_if ();

   assign rsn_if.vector = i_exc_vector;
   assign rsn_if.is_sw = i_exc_is_sw;
   assign rsn_if.fault_sel = detail_sel;

   exit_reason_encoder u_enc (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .rsn(rsn_if)
   );

   // requests that arrive while a frame is in flight are dropped, the core must wait
   assign accept = (state == frame_pkg::ST_IDLE) && i_exit_req;
   assign take = o_mem_valid && i_mem_ready;
   assign last_take = take && (slot == `LAST_SLOT);
   assign resume_ok = (state == frame_pkg::ST_IDLE) && i_resume && !i_exit_req;
   assign next_slot = slot + 5'd1;
   assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wb_wr = wb_req && i_wb_we;

   // frame end is base plus (index + 1) frames; region is top-aligned to it
   assign next_frame_end = frame_base +
      64'(({32'h00000000, frame_index} + 64'h1) * {32'h00000000, frame_size});

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wr[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // word for a slot, chosen by its byte offset within the region
   function automatic frame_pkg::qword_t slot_word(input logic [4:0] s);
      logic [7:0] off;
      frame_pkg::qword_t w;
      off = {s, 3'b000};
      w = 64'h0000000000000000;
      if (off < `OFF_FLAGS) begin
         w = gpr_lat[s[3:0]];
      end else begin
         unique case (off)
            `OFF_FLAGS: w = flags_lat;
            `OFF_RIP: w = rip_lat;
            `OFF_OSP: w = outside_stack_pointer;
            `OFF_OBP: w = outside_frame_pointer;
            // upper half holds the reserved field and is always zero
            `OFF_REASON: w = {32'h00000000, reason_lat};
            `OFF_FS: w = fs_segment_base;
            `OFF_GS: w = gs_segment_base;
            default: w = 64'h0000000000000000;
         endcase
      end
      return w;
   endfunction

   always_comb begin
      next_state = state;
      unique case (state)
         frame_pkg::ST_IDLE: begin
            if (accept) begin
               next_state = frame_pkg::ST_WRITE;
            end
         end
         frame_pkg::ST_WRITE: begin
            if (last_take) begin
               next_state = frame_pkg::ST_RESTORE;
            end
         end
         frame_pkg::ST_RESTORE: next_state = frame_pkg::ST_IDLE;
         default: next_state = frame_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= frame_pkg::ST_IDLE;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   // exception data is sampled at acceptance and held for the whole frame
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < `GPR_COUNT; i++) begin
            gpr_lat[i] <= 64'h0000000000000000;
         end
         flags_lat <= 64'h0000000000000000;
         rip_lat <= 64'h0000000000000000;
         fs_segment_base <= 64'h0000000000000000;
         gs_segment_base <= 64'h0000000000000000;
         reason_lat <= `RST_WORD;
         reported_lat <= 1'b0;
         region_base <= 64'h0000000000000000;
      end else if (i_ce && accept) begin
         for (int i = 0; i < `GPR_COUNT; i++) begin
            gpr_lat[i] <= i_gpr[i];
         end
         flags_lat <= i_flags;
         rip_lat <= i_rip;
         fs_segment_base <= i_fs_base;
         gs_segment_base <= i_gs_base;
         reason_lat <= rsn_if.word;
         reported_lat <= rsn_if.reported;
         region_base <= next_frame_end - `REGION_BYTES;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         outside_stack_pointer <= 64'h0000000000000000;
         outside_frame_pointer <= 64'h0000000000000000;
      end else if (i_ce && i_entry && (state == frame_pkg::ST_IDLE)) begin
         outside_stack_pointer <= i_entry_sp;
         outside_frame_pointer <= i_entry_bp;
      end
   end

   // memory port: one 8-byte slot per handshake, address is region base plus offset
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         slot <= 5'd0;
         o_mem_valid <= 1'b0;
         o_mem_addr <= 64'h0000000000000000;
         o_mem_data <= 64'h0000000000000000;
      end else if (i_ce) begin
         if (state == frame_pkg::ST_IDLE && accept) begin
            slot <= 5'd0;
            o_mem_valid <= 1'b1;
            o_mem_addr <= next_frame_end - `REGION_BYTES + {56'h0, `OFF_GPR0};
            // slot 0 data stands with valid from its first cycle, so any ready pattern is safe
            o_mem_data <= i_gpr[0];
         end else if (last_take) begin
            o_mem_valid <= 1'b0;
         end else if (take) begin
            slot <= next_slot;
            o_mem_addr <= region_base + {56'h0, next_slot, 3'b000};
            o_mem_data <= slot_word(next_slot);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_restore_valid <= 1'b0;
         o_restore_sp <= 64'h0000000000000000;
         o_restore_bp <= 64'h0000000000000000;
      end else if (i_ce) begin
         o_restore_valid <= last_take;
         if (last_take) begin
            o_restore_sp <= outside_stack_pointer;
            o_restore_bp <= outside_frame_pointer;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_busy <= 1'b0;
      end else if (i_ce) begin
         o_busy <= (next_state != frame_pkg::ST_IDLE);
      end
   end

   // frame index: hardware steps take priority over a software write in the same cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_index <= `RST_WORD;
      end else if (i_ce) begin
         if (accept) begin
            frame_index <= frame_index + 32'h1;
         end else if (resume_ok && frame_index != 32'h0) begin
            frame_index <= frame_index - 32'h1;
         end else if (wb_wr && i_wb_adr == `REG_FRAME_INDEX) begin
            frame_index <= merge(frame_index, i_wb_dat, i_wb_sel);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         detail_sel <= 1'b0;
         frame_base <= 64'h0000000000000000;
         frame_size <= `RST_FRAME_SIZE;
         irq_mask <= `RST_IRQ;
      end else if (i_ce && wb_wr) begin
         unique case (i_wb_adr)
            `REG_CTRL: begin
               if (i_wb_sel[0]) begin
                  detail_sel <= i_wb_dat[`CTRL_DETAIL_BIT];
               end
            end
            `REG_BASE_LO: frame_base[31:0] <= merge(frame_base[31:0], i_wb_dat, i_wb_sel);
            `REG_BASE_HI: frame_base[63:32] <= merge(frame_base[63:32], i_wb_dat, i_wb_sel);
            `REG_FRAME_SIZE: frame_size <= merge(frame_size, i_wb_dat, i_wb_sel);
            `REG_IRQ_MASK: begin
               if (i_wb_sel[0]) begin
                  irq_mask <= i_wb_dat[`IRQ_WIDTH-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         last_reason <= `RST_WORD;
      end else if (i_ce && last_take) begin
         last_reason <= reason_lat;
      end
   end

   // sticky events; a set in the same cycle as its clear survives
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_DONE_BIT] = last_take;
      irq_set[`IRQ_UNREP_BIT] = last_take && !reported_lat;
      irq_set[`IRQ_RESUME_BIT] = resume_ok;
      irq_clr = '0;
      if (wb_wr && i_wb_adr == `REG_IRQ_STATUS && i_wb_sel[0]) begin
         irq_clr = i_wb_dat[`IRQ_WIDTH-1:0];
      end
      next_status = (irq_status & ~irq_clr) | irq_set;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_status <= `RST_IRQ;
         o_irq <= 1'b0;
      end else if (i_ce) begin
         irq_status <= next_status;
         o_irq <= |(next_status & irq_mask);
      end
   end

   always_comb begin
      rd_word = 32'h00000000;
      unique case (i_wb_adr)
         `REG_CTRL: rd_word[`CTRL_DETAIL_BIT] = detail_sel;
         `REG_BASE_LO: rd_word = frame_base[31:0];
         `REG_BASE_HI: rd_word = frame_base[63:32];
         `REG_FRAME_SIZE: rd_word = frame_size;
         `REG_FRAME_INDEX: rd_word = frame_index;
         `REG_LAST_REASON: rd_word = last_reason;
         `REG_IRQ_STATUS: rd_word[`IRQ_WIDTH-1:0] = irq_status;
         `REG_IRQ_MASK: rd_word[`IRQ_WIDTH-1:0] = irq_mask;
         default: rd_word = 32'h00000000;
      endcase
   end

   // one wait state; ack drops in the cycle after it is given
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else if (i_ce) begin
         o_wb_ack <= wb_req;
         if (wb_req) begin
            o_wb_dat <= i_wb_we ? 32'h00000000 : rd_word;
         end
      end
   end

   sequence s_accept;
      accept;
   endsequence

   sequence s_last;
      last_take;
   endsequence

   property p_index_step;
      @(posedge i_clk) disable iff (!i_arst_n || !i_ce)
      s_accept |=> frame_index == $past(frame_index) + 32'h1;
   endproperty
   a_index_step: assert property (p_index_step) else $error("index not incremented");

   property p_slot_addr;
      @(posedge i_clk) disable iff (!i_arst_n)
      o_mem_valid |-> o_mem_addr == region_base + {56'h0, slot, 3'b000};
   endproperty
   a_slot_addr: assert property (p_slot_addr) else $error("slot address wrong");

   property p_reason_slot;
      @(posedge i_clk) disable iff (!i_arst_n)
      o_mem_valid && i_mem_ready && {slot, 3'b000} == `OFF_REASON |->
         o_mem_data == {32'h00000000, reason_lat};
   endproperty
   a_reason_slot: assert property (p_reason_slot) else $error("reason slot wrong");

   property p_restore;
      @(posedge i_clk) disable iff (!i_arst_n || !i_ce)
      s_last |=> o_restore_valid && o_restore_sp == outside_stack_pointer &&
         o_restore_bp == outside_frame_pointer ##1 !o_restore_valid;
   endproperty
   a_restore: assert property (p_restore) else $error("pointer restore wrong");

   property p_gpr_slot;
      @(posedge i_clk) disable iff (!i_arst_n)
      take && slot < 5'd16 |-> o_mem_data == gpr_lat[slot[3:0]];
   endproperty
   a_gpr_slot: assert property (p_gpr_slot) else $error("register slot wrong");
endmodule

// *** hw/exit_reason_encoder.sv ***
// exit reason word encoder
`timescale 1ns/1ps
`include "frame_defs.svh"
module exit_reason_encoder (
   // clock and reset, used only by the checks
   input wire logic i_clk,
   input wire logic i_arst_n,
   // exception in, word out
   exit_reason_if.enc rsn
);
   logic always_set;
   logic detail_set;

   always_comb begin
      always_set = 1'b0;
      detail_set = 1'b0;
      unique case (rsn.vector) inside
         `VEC_DIVIDE, `VEC_DEBUG, `VEC_BREAK, `VEC_BOUND, `VEC_OPCODE,
         `VEC_FPU, `VEC_ALIGN, `VEC_SIMD: always_set = 1'b1;
         `VEC_GPROT, `VEC_PAGE: detail_set = 1'b1;
         default: ;
      endcase
   end

   always_comb begin
      rsn.reported = always_set | (detail_set & rsn.fault_sel);
      rsn.word = 32'h00000000;
      if (rsn.reported) begin
         rsn.word[`RSN_VALID_BIT] = 1'b1;
         // vector passes through unchanged, as ordinary dispatch numbers it
         rsn.word[`RSN_VEC_MSB:`RSN_VEC_LSB] = rsn.vector;
         rsn.word[`RSN_TYPE_MSB:`RSN_TYPE_LSB] = rsn.is_sw ? `TYPE_SW : `TYPE_HW;
      end
   end

   property p_always_valid;
      @(posedge i_clk) disable iff (!i_arst_n)
      always_set |-> rsn.word[`RSN_VALID_BIT] && rsn.word[`RSN_VEC_MSB:`RSN_VEC_LSB] == rsn.vector;
   endproperty
   a_always_valid: assert property (p_always_valid) else $error("fixed vector not reported");

   property p_detail_gate;
      @(posedge i_clk) disable iff (!i_arst_n)
      detail_set |-> rsn.word[`RSN_VALID_BIT] == rsn.fault_sel;
   endproperty
   a_detail_gate: assert property (p_detail_gate) else $error("detail vector gating wrong");

   property p_zero_mid;
      @(posedge i_clk) disable iff (!i_arst_n)
      rsn.word[`RSN_ZERO_MSB:`RSN_ZERO_LSB] == 20'h00000;
   endproperty
   a_zero_mid: assert property (p_zero_mid) else $error("middle bits not zero");

   property p_unrep_clear;
      @(posedge i_clk) disable iff (!i_arst_n)
      !(always_set || (detail_set && rsn.fault_sel)) |-> rsn.word == 32'h00000000;
   endproperty
   a_unrep_clear: assert property (p_unrep_clear) else $error("unreported word not clear");

   property p_type_code;
      @(posedge i_clk) disable iff (!i_arst_n)
      rsn.word[`RSN_VALID_BIT] |->
         rsn.word[`RSN_TYPE_MSB:`RSN_TYPE_LSB] == (rsn.is_sw ? `TYPE_SW : `TYPE_HW);
   endproperty
   a_type_code: assert property (p_type_code) else $error("exit category wrong");
endmodule

// *** shared/exit_reason_if.sv ***
// carrier between the frame writer and its exit reason encoder
`timescale 1ns/1ps
interface exit_reason_if;
   frame_pkg::vector_t vector;
   logic is_sw;
   logic fault_sel;
   logic [31:0] word;
   logic reported;
   modport enc (input vector, input is_sw, input fault_sel, output word, output reported);
   modport user (output vector, output is_sw, output fault_sel, input word, input reported);
endinterface

// *** shared/frame_defs.svh ***
// constants of the exit state frame writer: offsets, fields, reset values
`ifndef FRAME_DEFS_SVH
`define FRAME_DEFS_SVH

// frame geometry in bytes
`define SLOT_BYTES 8
`define SLOT_SHIFT 3
`define REGION_BYTES 64'h00000000000000b0
`define GPR_COUNT 16
`define OFF_GPR0 8'd0
`define OFF_FLAGS 8'd128
`define OFF_RIP 8'd136
`define OFF_OSP 8'd144
`define OFF_OBP 8'd152
`define OFF_REASON 8'd160
`define OFF_RSVD 8'd164
`define OFF_FS 8'd168
`define OFF_GS 8'd176
`define LAST_SLOT 5'd22

// exit reason word fields
`define RSN_VEC_MSB 7
`define RSN_VEC_LSB 0
`define RSN_TYPE_MSB 10
`define RSN_TYPE_LSB 8
`define RSN_ZERO_MSB 30
`define RSN_ZERO_LSB 11
`define RSN_VALID_BIT 31
`define TYPE_HW 3'h3
`define TYPE_SW 3'h6

// vectors reported inside the region; VEC_GPROT and VEC_PAGE only while the control detail bit is set
`define VEC_DIVIDE 8'h00
`define VEC_DEBUG 8'h01
`define VEC_BREAK 8'h03
`define VEC_BOUND 8'h05
`define VEC_OPCODE 8'h06
`define VEC_GPROT 8'h0d
`define VEC_PAGE 8'h0e
`define VEC_FPU 8'h10
`define VEC_ALIGN 8'h11
`define VEC_SIMD 8'h13

// register byte offsets
`define REG_CTRL 8'h00
`define REG_BASE_LO 8'h04
`define REG_BASE_HI 8'h08
`define REG_FRAME_SIZE 8'h0c
`define REG_FRAME_INDEX 8'h10
`define REG_LAST_REASON 8'h14
`define REG_IRQ_STATUS 8'h18
`define REG_IRQ_MASK 8'h1c

// control and interrupt bits
`define CTRL_DETAIL_BIT 0
`define IRQ_DONE_BIT 0
`define IRQ_UNREP_BIT 1
`define IRQ_RESUME_BIT 2
`define IRQ_WIDTH 3

// reset values
`define RST_FRAME_SIZE 32'h00001000
`define RST_WORD 32'h00000000
`define RST_IRQ 3'h0

`endif

// *** shared/frame_pkg.sv ***
// types shared by the exit state frame writer
package frame_pkg;
   typedef logic [63:0] qword_t;
   typedef logic [7:0] vector_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_RESTORE = 2'b11
   } wr_state_e;
endpackage
